// File: cec_top.sv
// converter enable control: axi4-lite command port, run and power-ok pin drive
// Operation
// R1: select pin high picks stored register 1, low picks register 0.
// R2: converters-on status is NAND of global run and bus on-state; read back.
// R3: status high pulls all three run outputs and power-ok low.
// R4: status low releases the three run outputs for soft-start.
// R5: power-ok stays low while converters are shut down.
// R6: timer holds power-ok low 50 us after status falls or select toggles.
// R7: reset returns the command interface to idle.
// R8: reset sets both stored divider codes to all ones.
// R9: reset forces converters-on status high, converters shut down.
// R10: a completed setup command enables the on/off sequencer.
// R11: two on commands in a row clear the status when run is high.
// R12: two off commands set the status; run low shuts down at once.
// R13: without a run pin, global run is treated as always high.
// R14: host should hold run low, then set select before configuring.
// R15: host should read back both registers and redo setup on mismatch.
// R16: host should confirm status low after on commands.
// R17: bus on-state changes only after two consecutive like commands.
// R18: on commands are ignored until a setup command has completed.
// R19: read-back byte is code, then status bit, then two zeros.
// R20: setup writes are rejected while run and bus on-state are high.
// R21: power-ok timer counts block clocks, length set by a parameter.
// R22: select and run pins are synchronised before edge detection.
`timescale 1ns/10ps
`include "cec_defs.svh"
`default_nettype none
module cec_top #(
	parameter int ADDR_W      = 8,
	parameter bit HAS_RUN_PIN = 1'b1,
	parameter int PG_CYCLES   = `CEC_PG_CYCLES
) (
	// clock and reset
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// axi4-lite write address
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	// axi4-lite write data
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	// axi4-lite write response
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	// axi4-lite read address
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	// axi4-lite read data
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// control inputs
	input  wire logic              sel_in,
	input  wire logic              global_run_input,
	// open-drain run outputs: cpu, io, clock supplies
	input  wire logic [2:0]        run_i,
	output logic [2:0]             run_o,
	output logic [2:0]             run_oe,
	// open-drain power-ok output
	input  wire logic              power_ok_i,
	output logic                   power_ok_o,
	output logic                   power_ok_oe,
	// status to the divider and the system
	output logic [4:0]             divider_code,
	output logic                   converters_on_status_n,
	output logic                   bus_on_state
);
	if (ADDR_W < 4 || ADDR_W > 32) begin : g_chk_addr
		$error("address width must be 4 to 32 bits");
	end
	if (PG_CYCLES < 1) begin : g_chk_pg
		$error("power-ok pulse needs at least one cycle");
	end
	// the command word fields must fit inside the data word
	if (`CEC_HI_MSB > 31) begin : g_chk_fields
		$error("command fields exceed the data word");
	end

	cec_ctl_if     u_ctl ();
	cec_pkg::cec_st_t st_r;
	cec_pkg::cec_st_t st_nxt;

	// synchronised pins, read-back bytes and decode results
	logic          run_lvl;
	logic          sel_lvl;
	logic [7:0]    rdbk_lo;
	logic [7:0]    rdbk_hi;
	logic [31:0]   stat_word;
	logic [2:0]    cmd_code;
	logic          wr_go;
	logic          rd_go;
	cec_pkg::cec_rsel_t ar_sel;
	cec_pkg::cec_rsel_t aw_sel;

	// pin synchroniser: two flops, so a pin change shows up two to
	// three clocks later in status and in the divider code
	cec_sync u_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.pins    ({global_run_input, sel_in}),
		.ctl     (u_ctl.sync_mp)
	);

	// power-ok low pulse timer, reloaded by every start
	cec_pulse_timer #(
		.CYCLES (PG_CYCLES)
	) u_tmr (
		.aclk    (aclk),
		.aresetn (aresetn),
		.ctl     (u_ctl.timer_mp)
	);

	assign sel_lvl = u_ctl.lvl[0];
	// run is forced high in the variant without the pin
	assign run_lvl = HAS_RUN_PIN ? u_ctl.lvl[1] : 1'b1; // R13

	// trigger on status falling, or a select toggle while converters run
	// a toggle while shut down is dropped: power-ok is low then anyway
	assign u_ctl.start = (st_r.converters_on_status_n_n_d & ~st_r.converters_on_status_n_n) // R6
		| (u_ctl.sel_tog & ~st_r.converters_on_status_n_n); // R6

	// read-back bytes: code in the top five bits, status, two zeros
	// both bytes carry the status bit, so either one confirms turn-on
	assign rdbk_lo = {st_r.reg0, st_r.converters_on_status_n_n, 2'b00}; // R19
	assign rdbk_hi = {st_r.reg1, st_r.converters_on_status_n_n, 2'b00}; // R19

	// status word shows block state and the sensed pin levels; the sensed
	// pins are only reported and never steer the converters,
	// so a stuck pin cannot hold them off
	always_comb begin
		stat_word = 32'h0000_0000;
		stat_word[`CEC_ST_CONVERTERS_ON_STATUS_N] = st_r.converters_on_status_n_n; // R2
		stat_word[`CEC_ST_BUSON] = st_r.bus_on;
		stat_word[`CEC_ST_SETUP] = st_r.setup_done;
		stat_word[`CEC_ST_PGPIN] = power_ok_i;
		stat_word[`CEC_ST_BUSY] = u_ctl.busy;
		stat_word[`CEC_ST_SEL] = sel_lvl;
		stat_word[`CEC_ST_RUN] = run_lvl;
		stat_word[`CEC_ST_CODE_LSB +: 5] = st_r.code_out;
		stat_word[`CEC_ST_PIN_LSB +: 3] = run_i;
	end

	// address decode for the write channel
	// unmapped or unaligned addresses fall through to the error select
	always_comb begin
		if (s_axi_awaddr == ADDR_W'(`CEC_CMD_OFS)) begin
			aw_sel = cec_pkg::SEL_CMD;
		end else if (s_axi_awaddr == ADDR_W'(`CEC_RDBK_OFS)) begin
			aw_sel = cec_pkg::SEL_RDBK;
		end else if (s_axi_awaddr == ADDR_W'(`CEC_STAT_OFS)) begin
			aw_sel = cec_pkg::SEL_STAT;
		end else begin
			aw_sel = cec_pkg::SEL_NONE;
		end
	end

	// address decode for the read channel
	// unmapped or unaligned addresses fall through to the error select
	always_comb begin
		if (s_axi_araddr == ADDR_W'(`CEC_CMD_OFS)) begin
			ar_sel = cec_pkg::SEL_CMD;
		end else if (s_axi_araddr == ADDR_W'(`CEC_RDBK_OFS)) begin
			ar_sel = cec_pkg::SEL_RDBK;
		end else if (s_axi_araddr == ADDR_W'(`CEC_STAT_OFS)) begin
			ar_sel = cec_pkg::SEL_STAT;
		end else begin
			ar_sel = cec_pkg::SEL_NONE;
		end
	end

	assign cmd_code = st_r.wdata[`CEC_CMD_MSB:`CEC_CMD_LSB];
	// a write goes once both halves are held and the last answer retired
	assign wr_go = st_r.aw_hold & st_r.w_hold & ~st_r.bvalid;
	// a read is taken whenever no read answer is pending
	assign rd_go = s_axi_arvalid & st_r.arready;

	// whole next state: bus handshakes, command sequencer, pin drive
	always_comb begin
		st_nxt = st_r;

		// responses retire on their ready
		// ready may be high early; an answer only retires once it is seen
		if (st_r.bvalid && s_axi_bready) begin
			st_nxt.bvalid = 1'b0;
		end
		if (st_r.rvalid && s_axi_rready) begin
			st_nxt.rvalid = 1'b0;
		end

		// address and data are taken in either order and held
		// each ready closes once its item is taken, so nothing is overrun
		if (s_axi_awvalid && st_r.awready) begin
			st_nxt.aw_hold = 1'b1;
			st_nxt.aw_sel = aw_sel;
		end
		if (s_axi_wvalid && st_r.wready) begin
			st_nxt.w_hold = 1'b1;
			st_nxt.wdata = s_axi_wdata;
			st_nxt.wstrb = s_axi_wstrb;
		end

		// reads; a read-back counts as a foreign command to the sequencer
		if (rd_go) begin
			st_nxt.rvalid = 1'b1;
			st_nxt.rresp = `CEC_RESP_OKAY;
			st_nxt.rdata = 32'h0000_0000;
			if (ar_sel == cec_pkg::SEL_RDBK) begin
				st_nxt.rdata = {16'h0000, rdbk_hi, rdbk_lo}; // R19
				// a read of the read-back word breaks a pending pair unless a write in the same clock completes it or carries an unused code
				st_nxt.seq = cec_pkg::SEQ_IDLE; // R17
			end else if (ar_sel == cec_pkg::SEL_STAT) begin
				st_nxt.rdata = stat_word; // R2
			end else if (ar_sel == cec_pkg::SEL_CMD) begin
				st_nxt.rdata = 32'h0000_0000;
			end else begin
				st_nxt.rresp = `CEC_RESP_SLVERR;
			end
		end

		// write executes once both halves are held; a full word is needed
		// because a partial command would arm the sequencer with stale bytes
		// a wrong target or strobe answers with an error and changes nothing
		if (wr_go) begin
			st_nxt.aw_hold = 1'b0;
			st_nxt.w_hold = 1'b0;
			st_nxt.bvalid = 1'b1;
			st_nxt.bresp = `CEC_RESP_OKAY;
			if (st_r.aw_sel != cec_pkg::SEL_CMD || st_r.wstrb != 4'hf) begin
				st_nxt.bresp = `CEC_RESP_SLVERR;
			end else begin
				case (cmd_code)
					`CEC_CMD_ON: begin
						// before setup an on command is dropped and clears a half pair
						if (!st_r.setup_done) begin
							st_nxt.seq = cec_pkg::SEQ_IDLE; // R18
						end else if (st_r.seq == cec_pkg::SEQ_ON1) begin
							st_nxt.bus_on = 1'b1; // R11
							st_nxt.seq = cec_pkg::SEQ_IDLE;
						end else begin
							st_nxt.seq = cec_pkg::SEQ_ON1; // R17
						end
					end
					`CEC_CMD_OFF: begin
						// off needs no setup, so shutdown is always reachable
						if (st_r.seq == cec_pkg::SEQ_OFF1) begin
							st_nxt.bus_on = 1'b0; // R12
							st_nxt.seq = cec_pkg::SEQ_IDLE;
						end else begin
							st_nxt.seq = cec_pkg::SEQ_OFF1; // R17
						end
					end
					`CEC_CMD_SETUP: begin
						st_nxt.seq = cec_pkg::SEQ_IDLE; // R17
						// codes are locked while the converters run
						// a rejected setup still answers okay; read-back reveals it
						if (!(run_lvl && st_r.bus_on)) begin // R20
							st_nxt.reg0 = st_r.wdata[`CEC_LO_MSB:`CEC_LO_LSB];
							st_nxt.reg1 = st_r.wdata[`CEC_HI_MSB:`CEC_HI_LSB];
							st_nxt.setup_done = 1'b1; // R10
						end
					end
					`CEC_CMD_RDBK: begin
						// the write form of read-back only breaks a pending pair
						st_nxt.seq = cec_pkg::SEQ_IDLE; // R17
					end
					default: begin
						// unused codes are ignored and leave a pending pair intact
						st_nxt.seq = st_r.seq;
					end
				endcase
			end
		end

		// converters-on status and everything it drives; the next on-state
		// is used so the status moves in the same clock as the command
		st_nxt.converters_on_status_n_n = ~(run_lvl & st_nxt.bus_on); // R2 R12
		st_nxt.converters_on_status_n_n_d = st_r.converters_on_status_n_n;
		st_nxt.code_out = sel_lvl ? st_nxt.reg1 : st_nxt.reg0; // R1
		st_nxt.run_oe = {3{st_nxt.converters_on_status_n_n}}; // R3 R4
		// the old status term covers the clock in which the status falls,
		// before the timer has loaded; without it power-ok would float for
		// one clock ahead of its low pulse
		st_nxt.pg_oe = st_r.converters_on_status_n_n | st_nxt.converters_on_status_n_n | u_ctl.start | u_ctl.busy; // R3 R5 R6

		// readies follow the held state so a new item waits for the old one
		// registered readies leave no path from valid to ready
		st_nxt.awready = ~st_nxt.aw_hold & ~st_nxt.bvalid;
		st_nxt.wready = ~st_nxt.w_hold & ~st_nxt.bvalid;
		st_nxt.arready = ~st_nxt.rvalid;

		// synchronous reset: idle port, all-ones codes, converters shut down
		// one low edge is enough here and in the synchronisers, which clear both stages at once
		if (!aresetn) begin
			st_nxt = '0;
			st_nxt.aw_sel = cec_pkg::SEL_NONE;
			st_nxt.seq = cec_pkg::SEQ_IDLE; // R7
			st_nxt.reg0 = `CEC_CODE_RST; // R8
			st_nxt.reg1 = `CEC_CODE_RST; // R8
			st_nxt.code_out = `CEC_CODE_RST;
			st_nxt.converters_on_status_n_n = 1'b1; // R9
			st_nxt.converters_on_status_n_n_d = 1'b1;
			st_nxt.run_oe = 3'h7; // R9
			st_nxt.pg_oe = 1'b1; // R9
		end
	end

	// single state register
	// every top output below except the constant levels run_o and power_ok_o is read straight from this register
	always_ff @(posedge aclk) begin
		st_r <= st_nxt;
	end

	// bus outputs
	// answers stand until their ready is sampled high
	assign s_axi_awready = st_r.awready;
	assign s_axi_wready = st_r.wready;
	assign s_axi_bvalid = st_r.bvalid;
	assign s_axi_bresp = st_r.bresp;
	assign s_axi_arready = st_r.arready;
	assign s_axi_rvalid = st_r.rvalid;
	assign s_axi_rresp = st_r.rresp;
	assign s_axi_rdata = st_r.rdata;

	// open-drain pins only ever pull low, so the driven level is a constant
	// an enable is high while its pin is pulled to ground
	assign run_o = 3'h0;
	assign run_oe = st_r.run_oe;
	assign power_ok_o = 1'b0;
	assign power_ok_oe = st_r.pg_oe;

	// status outputs
	// the divider follows select only after the synchroniser
	assign divider_code = st_r.code_out;
	assign converters_on_status_n = st_r.converters_on_status_n_n;
	assign bus_on_state = st_r.bus_on;
endmodule
`default_nettype wire

// File: cec_defs.svh
// constants for the converter enable control block: offsets, fields, resets, timing
`ifndef CEC_DEFS_SVH
`define CEC_DEFS_SVH

// register byte offsets
`define CEC_CMD_OFS        8'h00
`define CEC_RDBK_OFS       8'h04
`define CEC_STAT_OFS       8'h08

// command word fields: command code byte, then low and high data bytes
`define CEC_CMD_MSB        7
`define CEC_CMD_LSB        5
`define CEC_LO_MSB         15
`define CEC_LO_LSB         11
`define CEC_HI_MSB         23
`define CEC_HI_LSB         19

// command codes (top three bits of the command byte)
`define CEC_CMD_ON         3'h0
`define CEC_CMD_SETUP      3'h1
`define CEC_CMD_RDBK       3'h2
`define CEC_CMD_OFF        3'h3

// status register bit positions
`define CEC_ST_CONVERTERS_ON_STATUS_N        0
`define CEC_ST_BUSON       1
`define CEC_ST_SETUP       2
`define CEC_ST_PGPIN       3
`define CEC_ST_BUSY        4
`define CEC_ST_SEL         5
`define CEC_ST_RUN         6
`define CEC_ST_CODE_LSB    8
`define CEC_ST_PIN_LSB     16

// reset values and responses
`define CEC_CODE_RST       5'h1f
`define CEC_RESP_OKAY      2'h0
`define CEC_RESP_SLVERR    2'h2

// power-ok low pulse: 50 us at 50 MHz
`define CEC_PG_TIME_NS     50000
`define CEC_CLK_MHZ        50
`define CEC_PG_CYCLES      ((`CEC_PG_TIME_NS * `CEC_CLK_MHZ) / 1000)

`endif

// File: cec_pkg.sv
// types shared by the converter enable control block
package cec_pkg;

	// on/off command sequencer, one-hot
	typedef enum logic [2:0] {
		SEQ_IDLE = 3'b001,
		SEQ_ON1  = 3'b010,
		SEQ_OFF1 = 3'b100
	} cec_seq_t;

	// decoded register selector held between address and data
	typedef enum logic [1:0] {
		SEL_CMD  = 2'h0,
		SEL_RDBK = 2'h1,
		SEL_STAT = 2'h2,
		SEL_NONE = 2'h3
	} cec_rsel_t;

	// whole state of the top module
	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [1:0]  rresp;
		logic [31:0] rdata;
		logic        aw_hold;
		cec_rsel_t   aw_sel;
		logic        w_hold;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic [4:0]  reg0;
		logic [4:0]  reg1;
		logic        setup_done;
		logic        bus_on;
		cec_seq_t    seq;
		logic        converters_on_status_n_n;
		logic        converters_on_status_n_n_d;
		logic [4:0]  code_out;
		logic [2:0]  run_oe;
		logic        pg_oe;
	} cec_st_t;

endpackage

// File: cec_ctl_if.sv
// carrier between the top, the input synchroniser and the power-ok timer
`timescale 1ns/10ps
`default_nettype none
interface cec_ctl_if;
	logic [1:0] lvl;      // [0] register select, [1] global run
	logic       sel_tog;  // one-cycle pulse per register-select toggle
	logic       start;
	logic       busy;
	modport sync_mp  (output lvl, output sel_tog);
	modport timer_mp (input start, output busy);
	modport top_mp   (input lvl, input sel_tog, input busy, output start);
endinterface
`default_nettype wire

// File: cec_sync.sv
// two-flop synchroniser for select and run pins, with select toggle detect
`timescale 1ns/10ps
`default_nettype none
module cec_sync (
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// raw pin levels
	input  wire logic [1:0]  pins,
	// synchronised levels and toggle
	cec_ctl_if.sync_mp       ctl
);
	typedef struct packed {
		logic [1:0] ff1;
		logic [1:0] ff2;
		logic       sel_d;
		logic       tog;
	} cec_sync_st_t;

	cec_sync_st_t st_r;
	cec_sync_st_t st_nxt;

	// edge detect looks only at the second stage, never the first
	always_comb begin
		st_nxt = st_r;
		st_nxt.ff1 = pins;
		st_nxt.ff2 = st_r.ff1;
		st_nxt.sel_d = st_r.ff2[0];
		st_nxt.tog = st_r.ff2[0] ^ st_r.sel_d; // R22
		if (!aresetn) begin
			st_nxt = '0;
		end
	end

	always_ff @(posedge aclk) begin
		st_r <= st_nxt;
	end

	assign ctl.lvl = st_r.ff2;
	assign ctl.sel_tog = st_r.tog;
endmodule
`default_nettype wire

// File: cec_pulse_timer.sv
// retriggerable down-counter that holds power-ok low for a fixed cycle count
`timescale 1ns/10ps
`default_nettype none
module cec_pulse_timer #(
	parameter int CYCLES = 2500
) (
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// start in, busy out
	cec_ctl_if.timer_mp      ctl
);
	localparam int W = $clog2(CYCLES + 1);

	if (CYCLES < 1) begin : g_chk
		$error("pulse timer needs at least one cycle");
	end

	typedef struct packed {
		logic [W-1:0] cnt;
	} cec_tmr_st_t;

	cec_tmr_st_t st_r;
	cec_tmr_st_t st_nxt;

	// a new trigger reloads, so back-to-back toggles stretch the pulse
	always_comb begin
		st_nxt = st_r;
		if (ctl.start) begin
			st_nxt.cnt = W'(CYCLES); // R21
		end else if (st_r.cnt != '0) begin
			st_nxt.cnt = st_r.cnt - W'(1);
		end
		if (!aresetn) begin
			st_nxt = '0;
		end
	end

	always_ff @(posedge aclk) begin
		st_r <= st_nxt;
	end

	assign ctl.busy = (st_r.cnt != '0);
endmodule
`default_nettype wire

// File: cec_chk.sv
// concurrent checks on the converter enable control top ports
`timescale 1ns/10ps
`default_nettype none
module cec_chk #(
	parameter int PG_CYCLES = 20
) (
	// clock and reset
	input wire logic       aclk,
	input wire logic       aresetn,
	// bus answers
	input wire logic       s_axi_bvalid,
	input wire logic       s_axi_rvalid,
	// control pins
	input wire logic       sel_in,
	input wire logic       global_run_input,
	// pin drive and status
	input wire logic [2:0] run_oe,
	input wire logic       power_ok_oe,
	input wire logic [4:0] divider_code,
	input wire logic       converters_on_status_n,
	input wire logic       bus_on_state
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	int pg_cnt;
	// length of a power-ok low stretch while on; catches a timer that never expires
	always_ff @(posedge aclk) begin
		if (!aresetn || !power_ok_oe || converters_on_status_n)
			pg_cnt <= 0;
		else
			pg_cnt <= pg_cnt + 1;
	end
	sequence s_pg_hold; power_ok_oe [*8]; endsequence
	sequence s_bus_done; $rose(s_axi_bvalid); endsequence
	property p_rst;
		$rose(aresetn) |-> run_oe == 3'h7 && power_ok_oe && converters_on_status_n
			&& divider_code == 5'h1f && !bus_on_state;
	endproperty
	a_rst: assert property (p_rst) else $error("bad state after reset");
	property p_idle; $rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid; endproperty
	a_idle: assert property (p_idle) else $error("bus not idle after reset");
	property p_nand; !bus_on_state |-> converters_on_status_n; endproperty
	a_nand: assert property (p_nand) else $error("status low with bus off");
	property p_run; run_oe == {3{converters_on_status_n}}; endproperty
	a_run: assert property (p_run) else $error("run drive disagrees with status");
	property p_pgoff; $past(converters_on_status_n) |-> power_ok_oe; endproperty
	a_pgoff: assert property (p_pgoff) else $error("power-ok released while off");
	property p_pgon; $fell(converters_on_status_n) |-> s_pg_hold; endproperty
	a_pgon: assert property (p_pgon) else $error("power-ok pulse too short");
	property p_pglen; pg_cnt <= PG_CYCLES + 4; endproperty
	a_pglen: assert property (p_pglen) else $error("power-ok pulse too long");
	property p_sel; $changed(sel_in) && !converters_on_status_n |-> ##[1:8] power_ok_oe; endproperty
	a_sel: assert property (p_sel) else $error("no pulse on select toggle");
	property p_shut; $fell(global_run_input) |-> ##[1:8] converters_on_status_n; endproperty
	a_shut: assert property (p_shut) else $error("run low did not shut down");
	property p_bus; $changed(bus_on_state) |-> s_bus_done; endproperty
	a_bus: assert property (p_bus) else $error("on-state moved without a command");
endmodule

bind cec_top cec_chk #(.PG_CYCLES(PG_CYCLES)) u_chk (
	.aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_rvalid(s_axi_rvalid), .sel_in(sel_in), .global_run_input(global_run_input),
	.run_oe(run_oe), .power_ok_oe(power_ok_oe), .divider_code(divider_code),
	.converters_on_status_n(converters_on_status_n), .bus_on_state(bus_on_state)
);
`default_nettype wire

// File: cec_conv_model.sv
// converter run and power-ok pins: pull-ups, soft-start charge, open-drain wires
`timescale 1ns/10ps
`default_nettype none
module cec_conv_model #(
	parameter int SS_CYC = 4
) (
	// clock
	input wire logic       aclk,
	// pull-down enables from the block
	input wire logic [2:0] run_oe,
	input wire logic       pg_oe,
	// resolved pin levels
	output logic [2:0]     run_lvl,
	output logic           pg_lvl
);
	int ss;
	// soft-start cap charges only while all run pins are released
	always_ff @(posedge aclk) begin
		ss <= (|run_oe) ? 0 : ((ss < SS_CYC) ? ss + 1 : ss);
	end
	// a pulled pin reads low at once, a released run pin rises after the charge
	always_comb begin
		run_lvl = ~run_oe & {3{ss == SS_CYC}};
		pg_lvl = ~pg_oe;
	end
endmodule
`default_nettype wire

// File: converter_enable_control_test.sv
// self-checking bench for the converter enable control block
`timescale 1ns/10ps
`include "cec_defs.svh"
`default_nettype none
module converter_enable_control_test;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [7:0]  awaddr = 8'h00;
	logic [7:0]  araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic        arvalid = 1'b0, rready = 1'b0, sel = 1'b0, run = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid, pg_oe, pg_o, pg_lvl;
	logic        converters_on_status_n_n, bus_on;
	logic [1:0]  bresp, rresp, r;
	logic [31:0] rdata, d;
	logic [2:0]  run_o, run_oe, run_lvl;
	logic [4:0]  code;
	logic [3:0]  wstrb = 4'hf;
	int          num_errors = 0;
	int          total_checks = 0;

	// 50 mhz clock
	always #10 aclk = ~aclk;

	cec_top #(.PG_CYCLES(20)) DUT (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.sel_in(sel), .global_run_input(run), .run_i(run_lvl), .run_o(run_o),
		.run_oe(run_oe), .power_ok_i(pg_lvl), .power_ok_o(pg_o), .power_ok_oe(pg_oe),
		.divider_code(code), .converters_on_status_n(converters_on_status_n_n), .bus_on_state(bus_on)
	);

	cec_conv_model conv (.aclk(aclk), .run_oe(run_oe), .pg_oe(pg_oe),
		.run_lvl(run_lvl), .pg_lvl(pg_lvl));

	task automatic chk(input logic [31:0] s, input logic [31:0] e, input string m);
		total_checks++;
		if (s !== e) begin
			num_errors++;
			$display("MISMATCH at %0t: %s got %h exp %h", $time, m, s, e);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge aclk);
	endtask

	// address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		r = bresp;
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask

	function automatic logic [31:0] cw(input logic [2:0] c, input logic [4:0] a,
			input logic [4:0] b);
		return {8'h00, b, 3'h0, a, 3'h0, c, 5'h00};
	endfunction

	task automatic t_reset();
		chk(run_oe, 3'h7, "run drive");
		chk(pg_oe, 1'b1, "power-ok drive");
		chk(code, 5'h1f, "code");
		chk(bus_on, 1'b0, "on-state");
		chk(run_o, 3'h0, "run level");
		chk(pg_o, 1'b0, "power-ok level");
		rd(`CEC_CMD_OFS);
		chk(d, 32'h0, "command read");
		rd(`CEC_RDBK_OFS);
		chk(d, 32'h0000fcfc, "readback");
		rd(8'h0c);
		chk(r, `CEC_RESP_SLVERR, "unmapped read");
		wr(`CEC_RDBK_OFS, 32'h0);
		chk(r, `CEC_RESP_SLVERR, "read-only write");
		wstrb <= 4'h3;
		wr(`CEC_CMD_OFS, cw(`CEC_CMD_SETUP, 5'h0, 5'h0));
		chk(r, `CEC_RESP_SLVERR, "partial strobe");
		wstrb <= 4'hf;
		$display("test reset done");
	endtask

	task automatic t_setup();
		run <= 1'b0;
		wr(`CEC_CMD_OFS, cw(`CEC_CMD_ON, 5'h0, 5'h0));
		wr(`CEC_CMD_OFS, cw(`CEC_CMD_ON, 5'h0, 5'h0));
		tick(3);
		chk(bus_on, 1'b0, "on before setup");
		wr(`CEC_CMD_OFS, cw(`CEC_CMD_SETUP, 5'h0a, 5'h15));
		rd(`CEC_RDBK_OFS);
		chk(d, 32'h0000ac54, "readback after setup");
		sel <= 1'b1;
		tick(6);
		chk(code, 5'h15, "select high");
		sel <= 1'b0;
		tick(6);
		chk(code, 5'h0a, "select low");
		$display("test setup done");
	endtask

	task automatic t_on();
		run <= 1'b1;
		tick(6);
		chk(converters_on_status_n_n, 1'b1, "status with bus off");
		wr(`CEC_CMD_OFS, cw(`CEC_CMD_ON, 5'h0, 5'h0));
		wr(`CEC_CMD_OFS, cw(3'h4, 5'h0, 5'h0));
		wr(`CEC_CMD_OFS, cw(`CEC_CMD_ON, 5'h0, 5'h0));
		tick(3);
		chk(bus_on, 1'b1, "on-state");
		chk(converters_on_status_n_n, 1'b0, "status on");
		chk(run_oe, 3'h0, "run released");
		chk(pg_oe, 1'b1, "power-ok pulse");
		tick(30);
		chk(pg_oe, 1'b0, "power-ok end");
		chk(run_lvl, 3'h7, "soft-start done");
		rd(`CEC_STAT_OFS);
		chk(d, 32'h00070a4e, "status word");
		wr(`CEC_CMD_OFS, cw(`CEC_CMD_SETUP, 5'h03, 5'h04));
		rd(`CEC_RDBK_OFS);
		chk(d, 32'h0000a850, "locked regs");
		sel <= 1'b1;
		tick(6);
		chk(pg_oe, 1'b1, "toggle pulse");
		chk(code, 5'h15, "new code");
		tick(30);
		chk(pg_oe, 1'b0, "toggle pulse end");
		$display("test on done");
	endtask

	task automatic t_off();
		wr(`CEC_CMD_OFS, cw(`CEC_CMD_OFF, 5'h0, 5'h0));
		tick(3);
		chk(bus_on, 1'b1, "single off");
		wr(`CEC_CMD_OFS, cw(`CEC_CMD_OFF, 5'h0, 5'h0));
		tick(3);
		chk(converters_on_status_n_n, 1'b1, "status off");
		chk(run_oe, 3'h7, "run pulled");
		chk(pg_oe, 1'b1, "power-ok off");
		wr(`CEC_CMD_OFS, cw(`CEC_CMD_ON, 5'h0, 5'h0));
		wr(`CEC_CMD_OFS, cw(`CEC_CMD_ON, 5'h0, 5'h0));
		tick(3);
		chk(converters_on_status_n_n, 1'b0, "on again");
		run <= 1'b0;
		tick(6);
		chk(converters_on_status_n_n, 1'b1, "run low");
		chk(run_oe, 3'h7, "run low drive");
		$display("test off done");
	endtask

	// reset in mid-run: codes, drive and setup state must all start over
	task automatic t_rerst();
		aresetn <= 1'b0;
		tick(2);
		aresetn <= 1'b1;
		tick(1);
		chk(code, 5'h1f, "code after reset");
		chk(run_oe, 3'h7, "run drive after reset");
		chk(pg_oe, 1'b1, "power-ok after reset");
		chk(bus_on, 1'b0, "on-state after reset");
		run <= 1'b1;
		wr(`CEC_CMD_OFS, cw(`CEC_CMD_ON, 5'h0, 5'h0));
		wr(`CEC_CMD_OFS, cw(`CEC_CMD_ON, 5'h0, 5'h0));
		tick(3);
		chk(converters_on_status_n_n, 1'b1, "on ignored after reset");
		$display("test mid-run reset done");
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// watchdog cuts a hung handshake short
	initial begin
		repeat (5000) @(posedge aclk);
		num_errors++;
		$display("MISMATCH at %0t: watchdog expired", $time);
		conclude();
	end

	// reset, then the scenarios in order
	initial begin
		tick(5);
		aresetn <= 1'b1;
		tick(1);
		t_reset();
		t_setup();
		t_on();
		t_off();
		t_rerst();
		conclude();
	end
endmodule
`default_nettype wire
